// ==== verilog/swire_slave_regs.svh ====
// Purpose: Timing figures and command codes of the single-wire identity slave
// Assumes: Times in nanoseconds; core clock period given below
// Notes:   Cycle counts are derived inside the module from these figures
`ifndef SWIRE_SLAVE_REGS_SVH
`define SWIRE_SLAVE_REGS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CORE_CLK_PERIOD_NS 4

// ----------------------------------------
// Addressing command codes
// ----------------------------------------
`define CMD_READ_ID 8'h33
`define CMD_MATCH_ID 8'h55
`define CMD_SKIP_ADDR 8'hcc
`define CMD_SEARCH_ID 8'hf0
`define CMD_FAST_SKIP 8'h3c
`define CMD_FAST_MATCH 8'h69

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FAST_SPEED_RESET 1'b0

// ----------------------------------------
// Line timing, nanoseconds
// ----------------------------------------
`define RESET_DETECT_REG_NS 120000
`define RESET_DETECT_FAST_NS 16000
`define RESET_CLEAR_FAST_NS 480000
`define RESET_KEEP_FAST_NS 80000
`define PRESENCE_WAIT_REG_NS 30000
`define PRESENCE_WAIT_FAST_NS 3000
`define PRESENCE_LOW_REG_NS 120000
`define PRESENCE_LOW_FAST_NS 12000
`define SLOT_DELAY_REG_NS 30000
`define SLOT_DELAY_FAST_NS 3000

// ----------------------------------------
// Identity layout
// ----------------------------------------
`define ID_BITS 64
`define CMD_BITS 8

`endif

// ==== verilog/swire_slave_pkg.sv ====
// Purpose: Types shared by the single-wire identity slave
// Assumes: Constants come from swire_slave_regs.svh
// Notes:   Holds the state type and small arithmetic helpers
`default_nettype none
package swire_slave_pkg;

   // ----------------------------------------
   // Link layer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PRES_WAIT,
      ST_PRES_LOW,
      ST_CMD,
      ST_READ_ID,
      ST_MATCH,
      ST_SEARCH,
      ST_FUNC
   } link_state_t;

   // Least time to whole cycles, never below one
   function automatic int cyc_up(input int t_ns, input int period_ns);
      int c;
      c = (t_ns + period_ns - 1) / period_ns;
      return (c < 1) ? 1 : c;
   endfunction

   // CRC with X^8+X^5+X^4+1, lsb first over 56 bits
   function automatic logic [7:0] id_crc(input logic [55:0] data);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 0; i < 56; i++) begin
         fb = c[0] ^ data[i];
         c = {1'b0, c[7:1]};
         if (fb) begin
            c = c ^ 8'h8c;
         end
      end
      return c;
   endfunction

endpackage
`default_nettype wire

// ==== verilog/swire_id_slave.sv ====
// Purpose: Slave network layer of a single-wire open-drain bus
// Assumes: 250 MHz core clock; line sampled through two flip-flops
// Notes:   Function commands are left to the layer behind func_select
`include "swire_slave_regs.svh"
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// [RULE1] Line idles high; master must leave it high to resume a transaction.
// [RULE2] Low over 16 us fast or 120 us regular counts as reset.
// [RULE3] Access order: reset, addressing command, function command, data exchange.
// [RULE4] Master reset pulse is answered by a device presence pulse.
// [RULE5] After presence one of six eight-bit addressing commands follows.
// [RULE6] Read-identity 33h sends family code, 48-bit serial, then CRC.
// [RULE7] Master uses read-identity only with a single slave attached.
// [RULE8] Match-identity 55h compares 64 bits; mismatch idles until reset.
// [RULE9] Skip-addressing cch goes straight to function commands.
// [RULE10] Search f0h: send bit, send complement, then read master's choice.
// [RULE11] Search loser drops out until the next reset pulse.
// [RULE12] Fast-skip sets the fast-speed flag and skips addressing.
// [RULE13] Reset of 480 us or more clears the fast-speed flag.
// [RULE14] Master resets at fast speed and re-addresses after multidrop fast-skip.
// [RULE15] Fast-match 69h receives 64 bits fast; match sets fast-speed flag.
// [RULE16] Failed fast-match keeps existing fast speed, others stay regular.
// [RULE17] Master starts every waveform except the presence pulse.
// [RULE18] Regular timing unless fast-speed flag set; then fast for all.
// [RULE19] Device only pulls the line low, giving a wired-AND.
// [RULE20] Slot timing supports 16.3 kbit/s regular and 142 kbit/s fast.
// [RULE21] At fast speed a reset up to 80 us keeps fast speed.
// [RULE22] Presence waits 15-60 us then lows 60-240 us; fast 2-6, 8-24.
// [RULE23] Master fall starts slot delay: sample point or zero hold time.
// [RULE24] Last identity byte is CRC over first 56 bits, sent true.
// [RULE25] Identity bits lsb first; unknown command idles until reset.
module swire_id_slave #(
   parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
   parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0001, // Arbitrary value
   parameter int RESET_DETECT_REG_CYC = swire_slave_pkg::cyc_up(`RESET_DETECT_REG_NS, `CORE_CLK_PERIOD_NS),
   parameter int RESET_CLEAR_FAST_CYC = swire_slave_pkg::cyc_up(`RESET_CLEAR_FAST_NS, `CORE_CLK_PERIOD_NS),
   parameter int PRESENCE_WAIT_REG_CYC = swire_slave_pkg::cyc_up(`PRESENCE_WAIT_REG_NS, `CORE_CLK_PERIOD_NS),
   parameter int PRESENCE_LOW_REG_CYC = swire_slave_pkg::cyc_up(`PRESENCE_LOW_REG_NS, `CORE_CLK_PERIOD_NS),
   parameter int SLOT_DELAY_REG_CYC = swire_slave_pkg::cyc_up(`SLOT_DELAY_REG_NS, `CORE_CLK_PERIOD_NS)
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe,
   output logic fast_speed_flag,
   output logic func_select,
   output logic bus_reset
);

   // ----------------------------------------
   // Derived counts
   // ----------------------------------------
   localparam int RESET_DETECT_FAST_CYC = swire_slave_pkg::cyc_up(`RESET_DETECT_FAST_NS, `CORE_CLK_PERIOD_NS);
   localparam int PRESENCE_WAIT_FAST_CYC = swire_slave_pkg::cyc_up(`PRESENCE_WAIT_FAST_NS, `CORE_CLK_PERIOD_NS);
   localparam int PRESENCE_LOW_FAST_CYC = swire_slave_pkg::cyc_up(`PRESENCE_LOW_FAST_NS, `CORE_CLK_PERIOD_NS);
   localparam int SLOT_DELAY_FAST_CYC = swire_slave_pkg::cyc_up(`SLOT_DELAY_FAST_NS, `CORE_CLK_PERIOD_NS);
   localparam int CW = 20;
   localparam logic [63:0] IDENT = {swire_slave_pkg::id_crc({SERIAL_NUMBER, FAMILY_CODE}),
                                    SERIAL_NUMBER, FAMILY_CODE}; // [RULE6] [RULE24]

   generate
      if (RESET_CLEAR_FAST_CYC >= (1 << CW) || RESET_DETECT_REG_CYC > RESET_CLEAR_FAST_CYC ||
          PRESENCE_LOW_REG_CYC >= (1 << CW) || PRESENCE_WAIT_REG_CYC >= (1 << CW) ||
          SLOT_DELAY_REG_CYC >= (1 << CW) || SLOT_DELAY_REG_CYC < 3) begin : g_bad_counts
         $error("swire_id_slave: timing counts out of range");
      end
   endgenerate

   // ----------------------------------------
   // Line synchroniser and edges
   // ----------------------------------------
   logic line_s1_r;
   logic line_s2_r;
   logic line_d_r;
   logic fall;
   logic rise;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         line_s1_r <= 1'b1;
         line_s2_r <= 1'b1;
         line_d_r <= 1'b1;
      end else begin
         line_s1_r <= line_in;
         line_s2_r <= line_s1_r;
         line_d_r <= line_s2_r;
      end
   end

   assign fall = line_d_r & ~line_s2_r;
   assign rise = ~line_d_r & line_s2_r;

   // ----------------------------------------
   // Reset pulse measurement
   // ----------------------------------------
   swire_slave_pkg::link_state_t state_r;
   logic [CW-1:0] low_cnt_r;
   logic [CW-1:0] tmr_r;
   logic oe_r;
   logic fm_pend_r;
   logic fast_r;
   logic timing_fast;
   logic rst_hit;
   logic [CW-1:0] det_cyc;
   logic [CW-1:0] wait_cyc;
   logic [CW-1:0] pres_cyc;
   logic [CW-1:0] slot_cyc;

   // Fast-match bits already arrive at fast timing
   assign timing_fast = fast_r | fm_pend_r; // [RULE18] [RULE20]
   assign det_cyc = timing_fast ? CW'(RESET_DETECT_FAST_CYC) : CW'(RESET_DETECT_REG_CYC);
   assign wait_cyc = timing_fast ? CW'(PRESENCE_WAIT_FAST_CYC) : CW'(PRESENCE_WAIT_REG_CYC);
   assign pres_cyc = timing_fast ? CW'(PRESENCE_LOW_FAST_CYC) : CW'(PRESENCE_LOW_REG_CYC);
   assign slot_cyc = timing_fast ? CW'(SLOT_DELAY_FAST_CYC) : CW'(SLOT_DELAY_REG_CYC);

   // Own pull-down is not counted, else presence looks like a reset
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_cnt_r <= '0;
      end else if (line_s2_r || oe_r) begin
         low_cnt_r <= '0;
      end else if (low_cnt_r != CW'(RESET_CLEAR_FAST_CYC)) begin
         low_cnt_r <= low_cnt_r + 1'b1;
      end
   end

   // Reset acts on the release edge, from any state
   assign rst_hit = rise && (low_cnt_r >= det_cyc); // [RULE2] [RULE4]

   // ----------------------------------------
   // Slot engine and addressing decode
   // ----------------------------------------
   logic slot_r;
   logic [5:0] bit_r;
   logic [1:0] phase_r;
   logic [7:0] cmd_r;
   logic miss_r;
   logic id_bit;
   logic tx_now;
   logic tx_bit;
   logic slot_end;
   logic bit_ok;
   logic [7:0] cmd_byte;
   logic cmd_done;
   logic match_done;
   logic match_ok;

   assign id_bit = IDENT[bit_r]; // [RULE25]
   assign tx_now = (state_r == swire_slave_pkg::ST_READ_ID) ||
                   (state_r == swire_slave_pkg::ST_SEARCH && phase_r != 2'd2);
   assign tx_bit = (state_r == swire_slave_pkg::ST_SEARCH && phase_r == 2'd1) ? ~id_bit : id_bit; // [RULE10]
   assign slot_end = slot_r && (tmr_r == slot_cyc - 1'b1);
   assign bit_ok = (line_s2_r == id_bit);
   assign cmd_byte = {line_s2_r, cmd_r[7:1]};
   assign cmd_done = slot_end && state_r == swire_slave_pkg::ST_CMD && bit_r == 6'(`CMD_BITS - 1); // [RULE5]
   assign match_done = slot_end && state_r == swire_slave_pkg::ST_MATCH && bit_r == 6'(`ID_BITS - 1);
   assign match_ok = match_done && !miss_r && bit_ok;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= swire_slave_pkg::ST_IDLE;
         tmr_r <= '0;
         slot_r <= 1'b0;
         oe_r <= 1'b0;
         bit_r <= '0;
         phase_r <= '0;
         cmd_r <= '0;
         miss_r <= 1'b0;
         fm_pend_r <= 1'b0;
      end else if (rst_hit) begin
         state_r <= swire_slave_pkg::ST_PRES_WAIT; // [RULE3] [RULE11]
         tmr_r <= '0;
         slot_r <= 1'b0;
         oe_r <= 1'b0;
         fm_pend_r <= 1'b0;
      end else begin
         case (state_r)
            swire_slave_pkg::ST_PRES_WAIT: begin
               tmr_r <= tmr_r + 1'b1;
               if (tmr_r == wait_cyc - 1'b1) begin
                  state_r <= swire_slave_pkg::ST_PRES_LOW;
                  tmr_r <= '0;
                  oe_r <= 1'b1; // [RULE22] [RULE17]
               end
            end
            swire_slave_pkg::ST_PRES_LOW: begin
               tmr_r <= tmr_r + 1'b1;
               if (tmr_r == pres_cyc - 1'b1) begin
                  state_r <= swire_slave_pkg::ST_CMD;
                  tmr_r <= '0;
                  oe_r <= 1'b0; // [RULE22]
                  bit_r <= '0;
               end
            end
            swire_slave_pkg::ST_CMD,
            swire_slave_pkg::ST_READ_ID,
            swire_slave_pkg::ST_MATCH,
            swire_slave_pkg::ST_SEARCH: begin
               if (!slot_r && fall) begin
                  slot_r <= 1'b1; // [RULE23]
                  tmr_r <= '0;
                  oe_r <= tx_now && !tx_bit; // [RULE19] [RULE23]
               end else if (slot_r) begin
                  tmr_r <= tmr_r + 1'b1;
                  if (slot_end) begin
                     slot_r <= 1'b0;
                     oe_r <= 1'b0;
                     bit_r <= bit_r + 1'b1;
                     case (state_r)
                        swire_slave_pkg::ST_CMD: begin
                           cmd_r <= cmd_byte;
                           if (cmd_done) begin
                              bit_r <= '0;
                              phase_r <= '0;
                              miss_r <= 1'b0;
                              case (cmd_byte)
                                 `CMD_READ_ID: state_r <= swire_slave_pkg::ST_READ_ID; // [RULE6]
                                 `CMD_MATCH_ID: state_r <= swire_slave_pkg::ST_MATCH; // [RULE8]
                                 `CMD_SKIP_ADDR: state_r <= swire_slave_pkg::ST_FUNC; // [RULE9]
                                 `CMD_SEARCH_ID: state_r <= swire_slave_pkg::ST_SEARCH; // [RULE10]
                                 `CMD_FAST_SKIP: state_r <= swire_slave_pkg::ST_FUNC; // [RULE12]
                                 `CMD_FAST_MATCH: begin
                                    state_r <= swire_slave_pkg::ST_MATCH; // [RULE15]
                                    fm_pend_r <= 1'b1;
                                 end
                                 default: state_r <= swire_slave_pkg::ST_IDLE; // [RULE25]
                              endcase
                           end
                        end
                        swire_slave_pkg::ST_READ_ID: begin
                           // After the identity the function layer owns the line
                           if (bit_r == 6'(`ID_BITS - 1)) begin
                              state_r <= swire_slave_pkg::ST_FUNC;
                           end
                        end
                        swire_slave_pkg::ST_MATCH: begin
                           if (!bit_ok) begin
                              miss_r <= 1'b1;
                           end
                           if (match_done) begin
                              fm_pend_r <= 1'b0; // [RULE16]
                              state_r <= match_ok ? swire_slave_pkg::ST_FUNC : swire_slave_pkg::ST_IDLE; // [RULE8]
                           end
                        end
                        swire_slave_pkg::ST_SEARCH: begin
                           if (phase_r != 2'd2) begin
                              bit_r <= bit_r;
                              phase_r <= phase_r + 1'b1;
                           end else if (!bit_ok) begin
                              state_r <= swire_slave_pkg::ST_IDLE; // [RULE11]
                           end else begin
                              phase_r <= '0;
                              if (bit_r == 6'(`ID_BITS - 1)) begin
                                 state_r <= swire_slave_pkg::ST_FUNC;
                              end
                           end
                        end
                        default: begin
                           state_r <= state_r;
                        end
                     endcase
                  end
               end
            end
            default: begin
               // Idle and function phase: wait for the next reset pulse
               slot_r <= 1'b0;
               oe_r <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Fast-speed flag
   // ----------------------------------------
   // A long reset may land mid-slot; clearing is judged on release only
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fast_r <= `FAST_SPEED_RESET;
      end else if (rst_hit) begin
         if (low_cnt_r >= CW'(RESET_CLEAR_FAST_CYC)) begin
            fast_r <= 1'b0; // [RULE13]
         end else begin
            fast_r <= fast_r; // [RULE21]
         end
      end else if (cmd_done && cmd_byte == `CMD_FAST_SKIP) begin
         fast_r <= 1'b1; // [RULE12]
      end else if (match_ok && fm_pend_r) begin
         fast_r <= 1'b1; // [RULE15]
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         line_out <= 1'b0;
         line_oe <= 1'b0;
         fast_speed_flag <= `FAST_SPEED_RESET;
         func_select <= 1'b0;
         bus_reset <= 1'b0;
      end else begin
         line_out <= 1'b0; // [RULE19] [RULE1]
         line_oe <= oe_r;
         fast_speed_flag <= fast_r;
         func_select <= (state_r == swire_slave_pkg::ST_FUNC) && !rst_hit; // [RULE3]
         bus_reset <= rst_hit;
      end
   end

endmodule
`default_nettype wire

// ==== test/swire_id_slave_assertions.sv ====
// Purpose: Concurrent checks on the single-wire identity slave ports
// Assumes: One clock domain; long counts shortened through parameters
// Notes:   Bound into every instance of the slave
`timescale 1ns/1ns
`default_nettype none
module swire_id_slave_checker #(
   parameter int RESET_DETECT_REG_CYC = 30000,
   parameter int RESET_CLEAR_FAST_CYC = 120000,
   parameter int PRESENCE_WAIT_REG_CYC = 7500,
   parameter int PRESENCE_LOW_REG_CYC = 30000,
   parameter int SLOT_DELAY_REG_CYC = 7500
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic line_in,
   input wire logic line_out,
   input wire logic line_oe,
   input wire logic fast_speed_flag,
   input wire logic func_select,
   input wire logic bus_reset
);
   localparam int PW_A = PRESENCE_WAIT_REG_CYC - 11;
   localparam int PW_B = PRESENCE_WAIT_REG_CYC - 1;
   localparam int PL_A = PRESENCE_LOW_REG_CYC - 3;
   localparam int PL_B = PRESENCE_LOW_REG_CYC + 3;
   localparam int SD_A = SLOT_DELAY_REG_CYC - 6;
   localparam int SD_B = SLOT_DELAY_REG_CYC + 3;
   logic [15:0] low_cnt_r;
   logic [15:0] last_low_r;
   logic [15:0] oe_len_r;
   logic line_d_r;
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   // Own pull-down is not counted: a read zero must never look like a reset
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_cnt_r <= 16'h0000;
      end else if (line_in) begin
         low_cnt_r <= 16'h0000;
      end else if (!line_oe) begin
         low_cnt_r <= low_cnt_r + 16'h0001;
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         line_d_r <= 1'b1;
         last_low_r <= 16'h0000;
      end else begin
         line_d_r <= line_in;
         if (line_in && !line_d_r) begin
            last_low_r <= low_cnt_r;
         end
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         oe_len_r <= 16'h0000;
      end else begin
         oe_len_r <= line_oe ? oe_len_r + 16'h0001 : 16'h0000;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence pres_start_s;
      bus_reset && !fast_speed_flag;
   endsequence
   sequence pres_rise_s;
      (!line_oe) [*8] ##[PW_A:PW_B] $rose(line_oe);
   endsequence
   pull_only_a: assert property (line_out == 1'b0)
      else $error("device drives line high");
   reset_pulse_a: assert property (bus_reset |=> !bus_reset)
      else $error("bus reset longer than one cycle");
   reset_len_a: assert property (bus_reset |-> last_low_r >= RESET_DETECT_REG_CYC - 4)
      else $error("bus reset after short low");
   pres_wait_a: assert property (pres_start_s |-> pres_rise_s)
      else $error("presence wait out of window");
   oe_len_a: assert property ($fell(line_oe) && !fast_speed_flag |->
      oe_len_r inside {[PL_A:PL_B], [SD_A:SD_B]}) else $error("pull-down length wrong");
   oe_bound_a: assert property (oe_len_r <= 16'h0bbc)
      else $error("pull-down held too long");
   fast_set_a: assert property ($rose(fast_speed_flag) |-> ##[0:2] func_select)
      else $error("fast flag set without addressing");
   fast_clear_a: assert property ($fell(fast_speed_flag) |-> last_low_r >= RESET_CLEAR_FAST_CYC - 4)
      else $error("fast flag cleared by short reset");
   func_quiet_a: assert property (func_select |-> !line_oe)
      else $error("line driven in function phase");
endmodule
bind swire_id_slave swire_id_slave_checker #(
   .RESET_DETECT_REG_CYC(RESET_DETECT_REG_CYC),
   .RESET_CLEAR_FAST_CYC(RESET_CLEAR_FAST_CYC),
   .PRESENCE_WAIT_REG_CYC(PRESENCE_WAIT_REG_CYC),
   .PRESENCE_LOW_REG_CYC(PRESENCE_LOW_REG_CYC),
   .SLOT_DELAY_REG_CYC(SLOT_DELAY_REG_CYC)
) u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
   .fast_speed_flag(fast_speed_flag), .func_select(func_select), .bus_reset(bus_reset));
`default_nettype wire

// ==== test/swire_master_model.sv ====
// Purpose: Behavioural bus master for the single-wire line
// Assumes: Sole master, single slave; line resolved with pull-up outside
// Notes:   slot_cyc is set by the bench to match the slave's speed
`timescale 1ns/1ns
`default_nettype none
module swire_master_model (
   input wire logic core_clk,
   input wire logic line,
   output logic mst_oe
);
   int slot_cyc = 30;
   initial mst_oe = 1'b0;
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Every waveform starts with our pull; released line idles high
   task automatic reset_pulse(input int len, output logic pres);
      pres = 1'b0;
      @(posedge core_clk);
      mst_oe <= 1'b1;
      hold(len);
      mst_oe <= 1'b0;
      repeat (slot_cyc * 5 + 100) begin
         @(posedge core_clk);
         if (line === 1'b0) begin
            pres = 1'b1;
         end else if (pres) begin
            break;
         end
      end
   endtask
   // Zero held past the slave's sample point, one released early
   task automatic wbit(input logic b);
      @(posedge core_clk);
      mst_oe <= 1'b1;
      hold(b ? 2 : slot_cyc + 6);
      mst_oe <= 1'b0;
      hold(b ? slot_cyc + 6 : 3);
   endtask
   task automatic rbit(output logic b);
      @(posedge core_clk);
      mst_oe <= 1'b1;
      hold(6);
      mst_oe <= 1'b0;
      hold(slot_cyc / 2);
      b = line;
      hold(slot_cyc / 2 + 8);
   endtask
   // Eight bits, lsb first
   task automatic wbyte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         wbit(v[i]);
      end
   endtask
endmodule
`default_nettype wire

// ==== test/swire_id_slave_tb.sv ====
// Purpose: Self-checking bench of the single-wire identity slave
// Assumes: One slave on the line; shortened regular counts
// Notes:   Fast counts are fixed in the slave, so fast traffic is kept short
`include "swire_slave_regs.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) chk_val(64'(got), 64'(exp))
module swire_id_slave_tb;
   // Slave's own default identity, left unset at the instance
   localparam logic [7:0] FAM = 8'h5a; // Arbitrary value
   localparam logic [47:0] SER = 48'h0000_0000_0001; // Arbitrary value
   logic core_clk;
   logic sys_rst;
   logic line_in;
   logic line_out;
   logic line_oe;
   logic fast_speed_flag;
   logic func_select;
   logic bus_reset;
   logic mst_oe;
   logic [63:0] id;
   int error_cnt = 0;
   int n_tests = 0;
   assign line_in = !(mst_oe || (line_oe && !line_out));
   swire_id_slave #(.RESET_DETECT_REG_CYC(200),
      .RESET_CLEAR_FAST_CYC(5000), .PRESENCE_WAIT_REG_CYC(20), .PRESENCE_LOW_REG_CYC(60),
      .SLOT_DELAY_REG_CYC(30)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .line_in(line_in),
      .line_out(line_out), .line_oe(line_oe), .fast_speed_flag(fast_speed_flag),
      .func_select(func_select), .bus_reset(bus_reset));
   swire_master_model u_mst (.core_clk(core_clk), .line(line_in), .mst_oe(mst_oe));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = !core_clk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   function automatic logic [63:0] exp_id();
      logic [55:0] d;
      logic [7:0] c;
      d = {SER, FAM};
      c = 8'h00;
      for (int i = 0; i < 56; i++) begin
         c = (c[0] ^ d[i]) ? ({1'b0, c[7:1]} ^ 8'h8c) : {1'b0, c[7:1]};
      end
      return {c, d};
   endfunction
   task automatic start(input logic [7:0] cmd, input int len);
      logic p;
      u_mst.reset_pulse(len, p);
      `CHECK(p, 1'b1);
      u_mst.wbyte(cmd);
      u_mst.hold(2);
   endtask
   task automatic rd64(output logic [63:0] v);
      logic b;
      for (int i = 0; i < 64; i++) begin
         u_mst.rbit(b);
         v[i] = b;
      end
   endtask
   task automatic wr_bits(input logic [63:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         u_mst.wbit(v[i]);
      end
   endtask
   // Master flips its choice at bit k; k above 62 walks the whole identity
   task automatic search_pass(input int k);
      logic b;
      for (int i = 0; i <= ((k > 62) ? 63 : k + 1); i++) begin
         u_mst.rbit(b);
         `CHECK(b, (i > k) ? 1'b1 : id[i]);
         u_mst.rbit(b);
         `CHECK(b, (i > k) ? 1'b1 : !id[i]);
         u_mst.wbit(id[i] ^ (i == k));
      end
   endtask
   initial begin
      repeat (120000) @(posedge core_clk);
      error_cnt++;
      end_sim();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic b;
      logic [63:0] got;
      logic [7:0] cmd;
      int k;
      sys_rst = 1'b1;
      id = exp_id();
      void'($urandom(52));
      repeat (3) @(posedge core_clk);
      `CHECK({line_oe, fast_speed_flag, func_select, bus_reset}, 4'h0);
      sys_rst <= 1'b0;
      start(`CMD_READ_ID, 300);
      rd64(got);
      `CHECK(got, id);
      `CHECK(func_select, 1'b1);
      $display("test read_id done");
      start(`CMD_SKIP_ADDR, 250);
      `CHECK(func_select, 1'b1);
      u_mst.rbit(b);
      `CHECK(b, 1'b1);
      $display("test skip done");
      start(`CMD_MATCH_ID, 300);
      wr_bits(id, 64);
      `CHECK(func_select, 1'b1);
      k = $urandom_range(63, 0);
      start(`CMD_MATCH_ID, 200);
      wr_bits(id ^ (64'h1 << k), 64);
      `CHECK(func_select, 1'b0);
      u_mst.rbit(b);
      `CHECK(b, 1'b1);
      $display("test match done");
      start(`CMD_SEARCH_ID, 300);
      search_pass(64);
      start(`CMD_SEARCH_ID, 300);
      search_pass($urandom_range(62, 0));
      $display("test search done");
      do cmd = 8'($urandom); while (cmd inside {8'h33, 8'h55, 8'hcc, 8'hf0, 8'h3c, 8'h69});
      start(cmd, 300);
      `CHECK(func_select, 1'b0);
      u_mst.rbit(b);
      `CHECK(b, 1'b1);
      $display("test unknown done");
      start(`CMD_FAST_SKIP, 300);
      `CHECK({fast_speed_flag, func_select}, 2'h3);
      u_mst.slot_cyc = 750;
      start(`CMD_FAST_MATCH, 4300);
      `CHECK(fast_speed_flag, 1'b1);
      wr_bits(~id, 1);
      `CHECK({fast_speed_flag, func_select}, 2'h2);
      u_mst.slot_cyc = 30;
      start(`CMD_FAST_MATCH, 5200);
      `CHECK(fast_speed_flag, 1'b0);
      u_mst.slot_cyc = 750;
      wr_bits(~id, 1);
      `CHECK(fast_speed_flag, 1'b0);
      u_mst.slot_cyc = 30;
      // Loser still runs fast slot timing, so only a long reset reaches it
      start(`CMD_FAST_MATCH, 5200);
      u_mst.slot_cyc = 750;
      wr_bits(id, 64);
      `CHECK({fast_speed_flag, func_select}, 2'h3);
      $display("test fast done");
      end_sim();
   end
endmodule
`default_nettype wire
